// ---- logic/sbr_top.sv ----
`timescale 1ns/100ps
`include "sbr_cfg.svh"
// Functional notes
// - sync mode bit rate is input clock over 8 times 4^n times N+1.
// - select 00 sysclk, 01 watch clock, 10 sysclk/16, 11 sysclk/64.
// - watch selection uses half the watch clock in active and sleep modes.
// - watch selection uses the undivided watch clock in subactive and subsleep.
// - n=0, N=0 async gives the maximum rate, sysclk over 64.
// - watch selection with N=0 gives the slow-oscillator maximum rate.
// - clock-stop bit 5 low puts the unit in standby; reset value is one.
// - in module standby all unit registers are held at initial values.
// - pin control bits 7 and 6 read one and ignore writes.
// - pin control bit 5 gives the shared pin to the transmitter.
// - pin control bit 3 inverts transmit data.
// - pin control bit 2 inverts receive data before the receiver.
// - async bit rate is input clock over 64 times 4^n times N+1.
// - divisor is read/write outside standby (writes in standby are ignored) and forced to FF on reset and standbys.
module sbr_top
  import sbr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watch_clk,
  input wire logic [3:0] power_mode,
  input wire logic unit_tx_data,
  input wire logic port_four_bit_two_out,
  output logic serial_tx_pin,
  input wire logic serial_rx_pin,
  output logic unit_rx_data,
  output logic unit_standby,
  output logic converter_clock_run,
  output logic timer_f_clock_run,
  output logic timer_a_clock_run,
  output logic [7:0] bit_rate_divisor,
  output logic bit_tick,
  output logic sample_tick
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] divisor_reg;
  logic [2:0] mode_reg;
  logic [7:0] clkstop_reg;
  logic [7:0] pinctl_reg;
  logic aw_reg, w_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic bresp_err_reg, rresp_err_reg;
  logic [1:0] wclk_sync_reg, rx_sync_reg;
  logic wclk_last_reg, wclk_half_reg;
  logic [2:0] sync_sub_reg;
  logic [5:0] async_sub_reg;
  logic [5:0] pre_cnt_reg;

  // ----------------------------------------
  // axi write path
  // ----------------------------------------
  wire wr_go = aw_reg & w_reg & ~bvalid_reg;
  wire wr_lane0 = wr_go & wstrb_reg[0];
  wire [7:0] wr_byte = wdata_reg[7:0];
  wire sel_div_w = (awaddr_reg == `SBR_OFF_DIVISOR);
  wire sel_mode_w = (awaddr_reg == `SBR_OFF_MODE);
  wire sel_cs_w = (awaddr_reg == `SBR_OFF_CLKSTOP);
  wire sel_pc_w = (awaddr_reg == `SBR_OFF_PINCTL);
  wire sel_st_w = (awaddr_reg == `SBR_OFF_STATUS);
  wire wr_hit = sel_div_w | sel_mode_w | sel_cs_w | sel_pc_w | sel_st_w;
  assign s_axi_awready = ~aw_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_err_reg ? 2'h2 : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_err_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_err_reg <= ~wr_hit;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  wire serial_run = clkstop_reg[`SBR_CS_SERIAL_RUN];
  wire unit_clear = ~serial_run | (power_mode == SBR_PM_OFF);
  assign unit_standby = ~serial_run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clkstop_reg <= `SBR_CLKSTOP_RST;
    end else if (wr_lane0 && sel_cs_w) begin
      clkstop_reg <= wdata_reg[7:0] | `SBR_CLKSTOP_FIXED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || unit_clear) begin
      divisor_reg <= `SBR_DIVISOR_RST;
      mode_reg <= `SBR_MODE_RST;
      pinctl_reg <= `SBR_PINCTL_RST;
    end else if (wr_lane0) begin
      if (sel_div_w) begin
        divisor_reg <= wdata_reg[7:0];
      end
      if (sel_mode_w) begin
        mode_reg <= wdata_reg[2:0];
      end
      if (sel_pc_w) begin
        pinctl_reg <= (wdata_reg[7:0] & 8'h2C) | `SBR_PINCTL_FIXED;
      end
    end
  end
  assign converter_clock_run = clkstop_reg[`SBR_CS_CONV_RUN];
  assign timer_f_clock_run = clkstop_reg[`SBR_CS_TIMF_RUN];
  assign timer_a_clock_run = clkstop_reg[`SBR_CS_TIMA_RUN];
  assign bit_rate_divisor = divisor_reg;

  // ----------------------------------------
  // axi read path
  // ----------------------------------------
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};
  wire [7:0] status_w = {6'h00, bit_tick, unit_standby};
  wire rd_hit = (rd_addr == `SBR_OFF_DIVISOR) | (rd_addr == `SBR_OFF_MODE) |
    (rd_addr == `SBR_OFF_CLKSTOP) | (rd_addr == `SBR_OFF_PINCTL) |
    (rd_addr == `SBR_OFF_STATUS);
  wire [7:0] rd_mux =
    (rd_addr == `SBR_OFF_DIVISOR) ? divisor_reg :
    (rd_addr == `SBR_OFF_MODE) ? {5'h00, mode_reg} :
    (rd_addr == `SBR_OFF_CLKSTOP) ? clkstop_reg :
    (rd_addr == `SBR_OFF_PINCTL) ? pinctl_reg :
    (rd_addr == `SBR_OFF_STATUS) ? status_w : 8'h00;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_err_reg ? 2'h2 : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_err_reg <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h0, rd_mux};
      rresp_err_reg <= ~rd_hit;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin path
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wclk_sync_reg <= 2'h0;
      rx_sync_reg <= 2'h3;
      wclk_last_reg <= 1'b0;
    end else begin
      wclk_sync_reg <= {wclk_sync_reg[0], watch_clk};
      rx_sync_reg <= {rx_sync_reg[0], serial_rx_pin};
      wclk_last_reg <= wclk_sync_reg[1];
    end
  end
  wire tx_func = pinctl_reg[`SBR_PC_TX_FUNC];
  wire tx_inv = pinctl_reg[`SBR_PC_TX_INV];
  wire rx_inv = pinctl_reg[`SBR_PC_RX_INV];
  assign serial_tx_pin = tx_func ? (unit_tx_data ^ tx_inv) : port_four_bit_two_out;
  assign unit_rx_data = rx_sync_reg[1] ^ rx_inv;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  wire wclk_rise = wclk_sync_reg[1] & ~wclk_last_reg;
  wire sub_mode = (power_mode == SBR_PM_SUB);
  wire watch_en = sub_mode ? wclk_rise : (wclk_rise & wclk_half_reg);
  wire [1:0] pre_sel = mode_reg[1:0];
  wire pre_en =
    (pre_sel == SBR_PRE_SYS) ? 1'b1 :
    (pre_sel == SBR_PRE_WATCH) ? watch_en :
    (pre_sel == SBR_PRE_DIV16) ? (pre_cnt_reg[3:0] == 4'hF) :
    (pre_cnt_reg == 6'h3F);
  always_ff @(posedge aclk) begin
    if (!aresetn || unit_clear) begin
      wclk_half_reg <= 1'b0;
      pre_cnt_reg <= 6'h00;
    end else begin
      if (wclk_rise) begin
        wclk_half_reg <= ~wclk_half_reg;
      end
      pre_cnt_reg <= pre_cnt_reg + 6'h01;
    end
  end

  // ----------------------------------------
  // bit-rate generator
  // ----------------------------------------
  logic n_tick;
  sbr_divcnt #(.W(8)) u_div (
    .aclk(aclk),
    .clr(~aresetn | unit_clear),
    .en(pre_en),
    .load(divisor_reg),
    .tick(n_tick)
  );
  wire sync_mode = mode_reg[`SBR_MD_SYNC];
  always_ff @(posedge aclk) begin
    if (!aresetn || unit_clear) begin
      sync_sub_reg <= 3'h0;
      async_sub_reg <= 6'h00;
    end else if (n_tick) begin
      sync_sub_reg <= sync_sub_reg + 3'h1;
      async_sub_reg <= async_sub_reg + 6'h01;
    end
  end
  // sample tick runs at 16x bit rate in async mode
  assign sample_tick = n_tick & (sync_mode ? (sync_sub_reg == `SBR_SYNC_SUB)
    : (async_sub_reg[1:0] == 2'h3));
  assign bit_tick = n_tick & (sync_mode ? (sync_sub_reg == `SBR_SYNC_SUB)
    : (async_sub_reg == `SBR_ASYNC_SUB));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_standby_div;
    @(posedge aclk) disable iff (!aresetn) !serial_run |=> divisor_reg == 8'hFF;
  endproperty
  a_standby_div: assert property (p_standby_div) else $error("divisor not forced");
  property p_pin_fixed;
    @(posedge aclk) disable iff (!aresetn) pinctl_reg[7:6] == 2'h3 && pinctl_reg[4] == 1'b0;
  endproperty
  a_pin_fixed: assert property (p_pin_fixed) else $error("pin control fixed bits");
  property p_cs_fixed;
    @(posedge aclk) disable iff (!aresetn) (clkstop_reg & 8'hCA) == 8'hCA;
  endproperty
  a_cs_fixed: assert property (p_cs_fixed) else $error("clock stop fixed bits");
  property p_standby_pin;
    @(posedge aclk) disable iff (!aresetn) !serial_run |=> pinctl_reg == 8'hC0;
  endproperty
  a_standby_pin: assert property (p_standby_pin) else $error("pin control not cleared");
  property p_tx_path;
    @(posedge aclk) disable iff (!aresetn)
      tx_func |-> serial_tx_pin == (unit_tx_data ^ tx_inv);
  endproperty
  a_tx_path: assert property (p_tx_path) else $error("tx pin path");
  property p_port_path;
    @(posedge aclk) disable iff (!aresetn) !tx_func |-> serial_tx_pin == port_four_bit_two_out;
  endproperty
  a_port_path: assert property (p_port_path) else $error("port pin path");
  property p_rx_path;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn) && $past(aresetn, 2)
      |-> unit_rx_data == ($past(serial_rx_pin, 2) ^ rx_inv);
  endproperty
  a_rx_path: assert property (p_rx_path) else $error("rx inversion");
  sequence s_fast_sync;
    sync_mode && pre_sel == 2'h0 && divisor_reg == 8'h00 && !unit_clear;
  endsequence
  property p_fast_sync;
    @(posedge aclk) disable iff (!aresetn) s_fast_sync [*8] |-> ##[0:7] bit_tick;
  endproperty
  a_fast_sync: assert property (p_fast_sync) else $error("sync rate wrong");
  property p_tick_gap;
    @(posedge aclk) disable iff (!aresetn) n_tick && divisor_reg == 8'h00 && pre_sel == 2'h0
      && !unit_clear |=> n_tick || unit_clear || $changed(divisor_reg) || $changed(pre_sel);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("divisor reload");
  property p_run_set;
    @(posedge aclk) disable iff (!aresetn)
      wr_lane0 && sel_cs_w && wr_byte[`SBR_CS_SERIAL_RUN] |=> serial_run;
  endproperty
  a_run_set: assert property (p_run_set) else $error("standby not released");
  property p_run_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr_lane0 && sel_cs_w && !wr_byte[`SBR_CS_SERIAL_RUN] |=> !serial_run;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("standby not entered");
  property p_standby_mode;
    @(posedge aclk) disable iff (!aresetn) !serial_run |=> mode_reg == 3'h0;
  endproperty
  a_standby_mode: assert property (p_standby_mode) else $error("mode not cleared");
  property p_standby_tick;
    @(posedge aclk) disable iff (!aresetn) unit_clear |=> !bit_tick;
  endproperty
  a_standby_tick: assert property (p_standby_tick) else $error("tick in standby");
  property p_watch_sub;
    @(posedge aclk) disable iff (!aresetn) sub_mode && wclk_rise |-> watch_en;
  endproperty
  a_watch_sub: assert property (p_watch_sub) else $error("sub mode watch rate");
  property p_watch_half;
    @(posedge aclk) disable iff (!aresetn)
      !sub_mode && wclk_rise && !wclk_half_reg |-> !watch_en;
  endproperty
  a_watch_half: assert property (p_watch_half) else $error("half watch rate");
  property p_tick_single;
    @(posedge aclk) disable iff (!aresetn) bit_tick |=> !bit_tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("bit tick too long");
  property p_div_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_lane0 && sel_div_w && !unit_clear |=> divisor_reg == $past(wr_byte);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divisor write lost");
  property p_pc_write;
    @(posedge aclk) disable iff (!aresetn) wr_lane0 && sel_pc_w && !unit_clear
      |=> pinctl_reg == (($past(wr_byte) & 8'h2C) | 8'hC0);
  endproperty
  a_pc_write: assert property (p_pc_write) else $error("pin control write");
endmodule

// ---- logic/sbr_cfg.svh ----
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SBR_OFF_DIVISOR 8'h00
`define SBR_OFF_MODE 8'h04
`define SBR_OFF_CLKSTOP 8'h08
`define SBR_OFF_PINCTL 8'h0C
`define SBR_OFF_STATUS 8'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define SBR_CS_SERIAL_RUN 5
`define SBR_CS_CONV_RUN 4
`define SBR_CS_TIMF_RUN 2
`define SBR_CS_TIMA_RUN 0
`define SBR_PC_TX_FUNC 5
`define SBR_PC_TX_INV 3
`define SBR_PC_RX_INV 2
`define SBR_MD_SYNC 2
// ----------------------------------------
// reset values and fixed bits
// ----------------------------------------
`define SBR_DIVISOR_RST 8'hFF
`define SBR_CLKSTOP_RST 8'hFF
`define SBR_CLKSTOP_FIXED 8'hCA
`define SBR_PINCTL_RST 8'hC0
`define SBR_PINCTL_FIXED 8'hC0
`define SBR_MODE_RST 3'h0
// ----------------------------------------
// timing counts
// ----------------------------------------
`define SBR_SYNC_SUB 3'h7
`define SBR_ASYNC_SUB 6'h3F
`endif

// ---- logic/sbr_pkg.sv ----
package sbr_pkg;
  typedef enum logic [1:0] {
    SBR_PRE_SYS = 2'h0,
    SBR_PRE_WATCH = 2'h1,
    SBR_PRE_DIV16 = 2'h2,
    SBR_PRE_DIV64 = 2'h3
  } sbr_pre_e;
  typedef enum logic [3:0] {
    SBR_PM_ACTIVE = 4'h1,
    SBR_PM_SLEEP = 4'h2,
    SBR_PM_SUB = 4'h4,
    SBR_PM_OFF = 4'h8
  } sbr_pm_e;
endpackage

// ---- logic/sbr_divcnt.sv ----
`timescale 1ns/100ps
// down-counter: one tick every (load+1) enables
module sbr_divcnt #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic clr,
  input wire logic en,
  input wire logic [W-1:0] load,
  output logic tick
);
  logic [W-1:0] cnt_reg;
  logic zero_w;
  assign zero_w = (cnt_reg == '0);
  assign tick = en & zero_w;
  always_ff @(posedge aclk) begin
    if (clr) begin
      cnt_reg <= load;
    end else if (en) begin
      cnt_reg <= zero_w ? load : cnt_reg - 1'b1;
    end
  end
endmodule

// ---- tb/sbr_peer.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// serial peer: watch crystal and receive line
// ----------------------------------------
module sbr_peer (
  input wire logic rx_level,
  output logic watch_clk,
  output logic serial_rx_pin
);
  // free-running crystal, 16 system clocks a period, phase unrelated
  initial begin
    watch_clk = 1'b0;
    #37;
    forever #800 watch_clk = ~watch_clk;
  end
  assign serial_rx_pin = rx_level;
endmodule

// ---- tb/serial_bitrate_standby_pin_control_test.sv ----
`timescale 1ns/100ps
`include "sbr_cfg.svh"
module serial_bitrate_standby_pin_control_test;
  import sbr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdat;
  logic [3:0] power_mode = SBR_PM_ACTIVE;
  logic tx_d = 1'b0;
  logic port_d = 1'b0;
  logic rx_level = 1'b0;
  logic watch_clk, rx_pin, tx_pin, rx_out, stby, conv_run, tf_run, ta_run, bit_tick, samp;
  logic [7:0] divisor;
  int failures = 0;
  int compares = 0;
  logic [2:0] md [8] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h5, 3'h1, 3'h4};
  logic [7:0] nv [8] = '{8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [3:0] pm [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h4, 4'h1, 4'h1};
  logic [31:0] ex [8] = '{32'h40, 32'h800, 32'h20, 32'h200, 32'h100, 32'h80, 32'h800, 32'h8};

  initial begin
    forever #50 aclk = ~aclk;
  end

  sbr_peer peer (.rx_level(rx_level), .watch_clk(watch_clk), .serial_rx_pin(rx_pin));

  sbr_top DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .watch_clk(watch_clk), .power_mode(power_mode), .unit_tx_data(tx_d),
    .port_four_bit_two_out(port_d), .serial_tx_pin(tx_pin), .serial_rx_pin(rx_pin),
    .unit_rx_data(rx_out), .unit_standby(stby), .converter_clock_run(conv_run),
    .timer_f_clock_run(tf_run), .timer_a_clock_run(ta_run),
    .bit_rate_divisor(divisor), .bit_tick(bit_tick), .sample_tick(samp)
  );

  // ----------------------------------------
  // report and bus helpers
  // ----------------------------------------
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        break;
      end
    end
    if (i == 50) begin
      failures++;
      close_out;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rdat = rdata;
        resp = rresp;
        break;
      end
    end
    if (i == 50) begin
      failures++;
      close_out;
    end
  endtask

  // cycles and sample ticks between the second and third bit tick
  task automatic per(input logic [31:0] e, input logic [31:0] es);
    int i, n;
    logic [31:0] c, s;
    n = 0;
    c = 0;
    s = 0;
    for (i = 0; i < 10000 && n < 3; i++) begin
      @(posedge aclk);
      if (n == 2) c++;
      if (n == 2 && samp === 1'b1) s++;
      if (bit_tick === 1'b1) n++;
    end
    if (n < 3) begin
      failures++;
      close_out;
    end
    chk(c, e);
    chk(s, es);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`SBR_OFF_DIVISOR); chk(rdat, 32'h0000_00FF);
    rd(`SBR_OFF_CLKSTOP); chk(rdat, 32'h0000_00FF);
    rd(`SBR_OFF_PINCTL); chk(rdat, 32'h0000_00C0);
    wr(`SBR_OFF_PINCTL, 32'h0000_002C);
    rd(`SBR_OFF_PINCTL); chk(rdat, 32'h0000_00EC);
    wr(`SBR_OFF_PINCTL, 32'h0000_0000);
    rd(`SBR_OFF_PINCTL); chk(rdat, 32'h0000_00C0);
    wr(8'h20, 32'h0000_0055); chk(resp, 2'h2);
    rd(8'h20); chk(resp, 2'h2);
  endtask

  task automatic t_pins;
    port_d <= 1'b1;
    tx_d <= 1'b0;
    rx_level <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(tx_pin, 1'b1);
    chk(rx_out, 1'b1);
    wr(`SBR_OFF_PINCTL, 32'h0000_0020);
    @(posedge aclk);
    chk(tx_pin, 1'b0);
    wr(`SBR_OFF_PINCTL, 32'h0000_002C);
    repeat (4) @(posedge aclk);
    chk(tx_pin, 1'b1);
    chk(rx_out, 1'b0);
  endtask

  task automatic t_standby;
    wr(`SBR_OFF_DIVISOR, 32'h0000_0012);
    wr(`SBR_OFF_MODE, 32'h0000_0003);
    wr(`SBR_OFF_CLKSTOP, 32'h0000_0000);
    rd(`SBR_OFF_CLKSTOP); chk(rdat, 32'h0000_00CA);
    chk({stby, conv_run, tf_run, ta_run}, 4'h8);
    rd(`SBR_OFF_STATUS); chk(rdat, 32'h0000_0001);
    rd(`SBR_OFF_DIVISOR); chk(rdat, 32'h0000_00FF);
    rd(`SBR_OFF_MODE); chk(rdat, 32'h0000_0000);
    rd(`SBR_OFF_PINCTL); chk(rdat, 32'h0000_00C0);
    wr(`SBR_OFF_CLKSTOP, 32'h0000_00FF);
    @(posedge aclk);
    chk({stby, conv_run, tf_run, ta_run}, 4'h7);
    wr(`SBR_OFF_DIVISOR, 32'h0000_0034);
    chk(divisor, 8'h34);
    power_mode <= SBR_PM_OFF;
    repeat (2) @(posedge aclk);
    power_mode <= SBR_PM_ACTIVE;
    rd(`SBR_OFF_DIVISOR); chk(rdat, 32'h0000_00FF);
  endtask

  task automatic t_rates;
    for (int k = 0; k < 8; k++) begin
      wr(`SBR_OFF_MODE, {29'h0, md[k]});
      wr(`SBR_OFF_DIVISOR, {24'h0, nv[k]});
      power_mode <= pm[k];
      per(ex[k], md[k][2] ? 32'h1 : 32'h10);
    end
    power_mode <= SBR_PM_ACTIVE;
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_pins;
    t_standby;
    t_rates;
    close_out;
  end
endmodule
